// ==== hw/qdc_serial_ctrl.sv ====
// serial control logic of a quad 12-bit voltage-output converter
//
// Functional notes
// - frame select low shifts data on falling edges
// - sixteenth falling edge executes the command
// - clock and data after sixteenth edge ignored
// - early select rise aborts frame unchanged
// - first two bits are the channel address
// - next two bits select the operation
// - last twelve bits are code, msb first
// - operation 11 powers down all channels
// - address field picks power-down output termination
// - power-down never alters channel registers
// - waking keeps registers unless frame writes them
// - power-up clears registers, outputs held zero
// - registers hold unsigned code 0 to 4095
// - serial clock rates up to 40 MHz
`timescale 1ns/10ps
`include "qdc_defs.svh"

module qdc_serial_ctrl
  import qdc_pkg::*;
#(
  parameter int NUM_CH = `QDC_NUM_CH,
  parameter int CODE_W = `QDC_CODE_BITS
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_SYNC_N,
  input wire logic I_SCLK,
  input wire logic I_SDATA,
  output logic [NUM_CH*CODE_W-1:0] O_CH_CODE,
  output logic [NUM_CH*CODE_W-1:0] O_OUT_CODE,
  output logic O_POWER_DOWN,
  output qdc_term_t O_TERM,
  output logic O_FRAME_DONE
);

  // -------------------------------------------------------------
  // reset release and pin synchronisers
  // -------------------------------------------------------------
  logic [1:0] rst_sync_reg; // reset release pipeline
  logic rst_n; // synchronised reset
  logic [2:0] pin_s1_reg; // first stage: sync, sclk, data
  logic [2:0] pin_s2_reg; // second stage
  logic sclk_d_reg; // delayed clock for edge detect

  // reset is asserted at once and released through two stages
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // link clock at up to 40 MHz is sampled by the 250 MHz clock
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: select high, clock high, data low, so no false edge
      pin_s1_reg <= 3'h3;
      pin_s2_reg <= 3'h3;
      sclk_d_reg <= 1'b1;
    end else begin
      pin_s1_reg <= {I_SDATA, I_SCLK, I_SYNC_N};
      pin_s2_reg <= pin_s1_reg;
      sclk_d_reg <= pin_s2_reg[1];
    end
  end

  logic sync_n; // synchronised frame select
  logic sdata; // synchronised data
  logic sclk_fall; // falling edge of the serial clock
  assign sync_n = pin_s2_reg[0];
  assign sdata = pin_s2_reg[2];
  assign sclk_fall = sclk_d_reg & ~pin_s2_reg[1];

  // -------------------------------------------------------------
  // frame shifter
  // -------------------------------------------------------------
  qdc_state_t state_reg, state_next; // frame state
  logic [`QDC_FRAME_BITS-1:0] shift_reg, shift_next; // input shifter
  logic [`QDC_BIT_CNT_W-1:0] cnt_reg, cnt_next; // bits received
  logic exec; // frame complete this cycle
  qdc_frame_t frame; // decoded frame

  // shifting, completion and abort
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    exec = 1'b0;
    frame = shift_next;
    unique case (state_reg)
      // wait for select to fall
      QDC_IDLE: begin
        cnt_next = '0;
        if (!sync_n) begin
          state_next = QDC_SHIFT;
        end
      end
      // shift bits on each falling clock edge
      QDC_SHIFT: begin
        if (sync_n) begin
          state_next = QDC_IDLE; // early rise, nothing applied
        end else if (sclk_fall) begin
          shift_next = {shift_reg[`QDC_FRAME_BITS-2:0], sdata};
          cnt_next = cnt_reg + `QDC_BIT_CNT_W'(1);
          if (cnt_reg == `QDC_BIT_CNT_W'(`QDC_FRAME_BITS - 1)) begin
            exec = 1'b1; // sixteenth edge completes the frame
            state_next = QDC_DONE;
          end
        end
      end
      // further edges ignored until select rises
      QDC_DONE: begin
        if (sync_n) begin
          state_next = QDC_IDLE;
        end
      end
      default: begin
        state_next = QDC_IDLE;
      end
    endcase
    frame = shift_next; // fields: address, op, code
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= QDC_IDLE;
      shift_reg <= '0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // -------------------------------------------------------------
  // channel registers, outputs and power-down
  // -------------------------------------------------------------
  logic [CODE_W-1:0] ch_reg [NUM_CH]; // channel registers
  logic [CODE_W-1:0] ch_next [NUM_CH];
  logic [CODE_W-1:0] out_reg [NUM_CH]; // codes driving the outputs
  logic [CODE_W-1:0] out_next [NUM_CH];
  logic pd_reg, pd_next; // power-down state
  qdc_term_t term_reg, term_next; // termination in power-down
  logic upd; // transfer registers to outputs

  // command decode shared by all channels
  always_comb begin
    upd = 1'b0;
    pd_next = pd_reg;
    term_next = term_reg;
    if (exec) begin
      unique case (frame.op)
        `QDC_OP_PWR_DN: begin
          pd_next = 1'b1; // all channels together
          unique case (frame.chan)
            `QDC_TERM_2K5: term_next = QDC_TERM_GND_2K5;
            `QDC_TERM_100K: term_next = QDC_TERM_GND_100K;
            default: term_next = QDC_TERM_NONE;
          endcase
        end
        `QDC_OP_WR_ONLY: pd_next = 1'b0; // register write wakes
        default: begin
          pd_next = 1'b0;
          upd = 1'b1;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // each channel loads its register and optionally its output
      always_comb begin
        ch_next[g] = ch_reg[g];
        out_next[g] = out_reg[g];
        if (exec && frame.op != `QDC_OP_PWR_DN) begin
          if (frame.op == `QDC_OP_WR_ALL ||
              frame.chan == 2'(g)) begin
            ch_next[g] = frame.code;
          end
        end
        if (upd) begin
          out_next[g] = ch_next[g];
        end
      end

      // power-on clear to code zero
      always_ff @(posedge I_REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
          ch_reg[g] <= `QDC_CODE_ZERO;
          out_reg[g] <= `QDC_CODE_ZERO;
          O_CH_CODE[g*CODE_W +: CODE_W] <= `QDC_CODE_ZERO;
          O_OUT_CODE[g*CODE_W +: CODE_W] <= `QDC_CODE_ZERO;
        end else begin
          ch_reg[g] <= ch_next[g];
          out_reg[g] <= out_next[g];
          O_CH_CODE[g*CODE_W +: CODE_W] <= ch_next[g];
          O_OUT_CODE[g*CODE_W +: CODE_W] <= out_next[g];
        end
      end
    end
  endgenerate

  // power-down state and completion pulse
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pd_reg <= 1'b0;
      term_reg <= QDC_TERM_NONE;
      O_POWER_DOWN <= 1'b0;
      O_TERM <= QDC_TERM_NONE;
      O_FRAME_DONE <= 1'b0;
    end else begin
      pd_reg <= pd_next;
      term_reg <= term_next;
      O_POWER_DOWN <= pd_next;
      O_TERM <= term_next;
      O_FRAME_DONE <= exec;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  chk_abort_no_change: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (state_reg == QDC_SHIFT && sync_n) |=> $stable(O_OUT_CODE) &&
      $stable(O_CH_CODE) && $stable(O_POWER_DOWN))
    else $error("aborted frame changed state");

  chk_done_ignores_clk: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (state_reg == QDC_DONE && sclk_fall) |=>
      $stable(shift_reg) && !O_FRAME_DONE)
    else $error("extra edge executed after frame end");

  chk_exec_at_sixteen: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    exec |-> cnt_reg == `QDC_BIT_CNT_W'(`QDC_FRAME_BITS - 1))
    else $error("frame executed at wrong bit count");

  chk_pd_keeps_regs: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (exec && frame.op == `QDC_OP_PWR_DN) |=>
      $stable(O_CH_CODE) && $stable(O_OUT_CODE))
    else $error("power-down altered a channel register");

  chk_pd_enter: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (exec && frame.op == `QDC_OP_PWR_DN) |=> O_POWER_DOWN)
    else $error("power-down not entered");

  chk_term_2k5: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (exec && frame.op == `QDC_OP_PWR_DN && frame.chan == `QDC_TERM_2K5)
      |=> O_TERM == QDC_TERM_GND_2K5)
    else $error("wrong termination selected");

  chk_wr_only_hold: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (exec && frame.op == `QDC_OP_WR_ONLY) |=> $stable(O_OUT_CODE))
    else $error("write-only changed outputs");

  chk_wr_all_load: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (exec && frame.op == `QDC_OP_WR_ALL) |=>
      O_OUT_CODE[CODE_W-1:0] == $past(frame.code))
    else $error("write-all did not update channel one");

  chk_shift_on_fall: assert property (
    @(posedge I_REF_CLK) disable iff (!rst_n)
    (state_reg == QDC_SHIFT && !sync_n && sclk_fall) |=>
      shift_reg[0] == $past(sdata))
    else $error("bit not shifted on falling edge");

endmodule

// ==== hw/qdc_defs.svh ====
// constant definitions for the quad converter serial control block
`ifndef QDC_DEFS_SVH
`define QDC_DEFS_SVH

`define QDC_FRAME_BITS 16
`define QDC_CODE_BITS 12
`define QDC_NUM_CH 4
`define QDC_BIT_CNT_W 5
`define QDC_OP_WR_ONLY 2'h0
`define QDC_OP_WR_UPD 2'h1
`define QDC_OP_WR_ALL 2'h2
`define QDC_OP_PWR_DN 2'h3
`define QDC_TERM_HIZ_A 2'h0
`define QDC_TERM_2K5 2'h1
`define QDC_TERM_100K 2'h2
`define QDC_TERM_HIZ_B 2'h3
`define QDC_CODE_ZERO 12'h000
`define QDC_CLK_PERIOD_NS 4
`define QDC_SCLK_MAX_MHZ 40

`endif

// ==== hw/qdc_pkg.sv ====
// type package for the quad converter serial control block
package qdc_pkg;

  // output termination while powered down
  typedef enum logic [1:0] {
    QDC_TERM_NONE,
    QDC_TERM_GND_2K5,
    QDC_TERM_GND_100K
  } qdc_term_t;

  // decoded frame fields in shift order
  typedef struct packed {
    logic [1:0] chan;
    logic [1:0] op;
    logic [11:0] code;
  } qdc_frame_t;

  // frame state of the serial port
  typedef enum logic [1:0] {
    QDC_IDLE,
    QDC_SHIFT,
    QDC_DONE
  } qdc_state_t;

endpackage

// ==== sim/qdc_host_model.sv ====
// serial host model that writes frames into the converter control
`timescale 1ns/10ps

module qdc_host_model (
  input wire logic i_clk,
  output logic o_sync_n,
  output logic o_sclk,
  output logic o_sdata
);
  localparam int HALF = 20; // half of the 160 ns link period, in ref cycles

  // idle: select and data parked low, clock stopped high
  initial begin
    o_sync_n = 1'b0;
    o_sclk = 1'b1;
    o_sdata = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame writer
  // ----------------------------------------------------------------
  // shifts nbits msb first; bits past the sixteenth are ones
  task automatic send(input logic [15:0] w, input int nbits);
    @(negedge i_clk);
    o_sync_n = 1'b1; // a frame starts from a raised select
    repeat (HALF) @(negedge i_clk);
    o_sync_n = 1'b0; // select falls while the clock is high
    for (int i = 0; i < nbits; i++) begin
      o_sdata = (i < 16) ? w[15-i] : 1'b1; // msb first
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b0; // falling edge takes the bit
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b1;
    end
    o_sdata = 1'b0;
    repeat (HALF) @(negedge i_clk);
    o_sync_n = 1'b1; // select raised to close the frame
    repeat (HALF) @(negedge i_clk);
    o_sync_n = 1'b0; // then parked low to save power
  endtask
endmodule

// ==== sim/quad_dac_serial_control_test.sv ====
// self-checking bench for the quad converter serial control
`timescale 1ns/10ps

module quad_dac_serial_control_test;
  import qdc_pkg::*;
  logic clk, rst_n, sync_n, sclk, sdata, pd, done;
  logic [47:0] ch_code, out_code;
  qdc_term_t term;
  logic [11:0] e [4]; // expected channel registers
  logic [47:0] eo; // expected applied codes
  int n_fail, compares, n_done;

  // 250 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  qdc_host_model host (.i_clk(clk), .o_sync_n(sync_n), .o_sclk(sclk),
    .o_sdata(sdata));
  qdc_serial_ctrl dut (.I_REF_CLK(clk), .I_RESETN(rst_n),
    .I_SYNC_N(sync_n), .I_SCLK(sclk), .I_SDATA(sdata),
    .O_CH_CODE(ch_code), .O_OUT_CODE(out_code), .O_POWER_DOWN(pd),
    .O_TERM(term), .O_FRAME_DONE(done));

  // counts executed frames
  always @(negedge clk) if (done === 1'b1) n_done++;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // sends one frame and checks whether it executed
  task automatic frame(input logic [1:0] ch, op, input logic [11:0] code,
                       input int nb);
    int d0;
    d0 = n_done;
    host.send({ch, op, code}, nb);
    chk("done", 48'(n_done - d0), 48'(nb >= 16));
  endtask

  task automatic cmp_all();
    chk("regs", ch_code, {e[3], e[2], e[1], e[0]});
    chk("outs", out_code, eo);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    cmp_all();
    chk("pd", 48'(pd), 48'h0);
    chk("term", 48'(term), 48'(QDC_TERM_NONE));
  endtask

  // write only: outputs keep their codes
  task automatic t_wr_only();
    frame(2'h2, 2'h0, 12'h5a5, 16);
    e[2] = 12'h5a5;
    cmp_all();
  endtask

  // write one channel and apply all
  task automatic t_wr_upd();
    frame(2'h1, 2'h1, 12'h3c7, 16);
    e[1] = 12'h3c7;
    eo = {e[3], e[2], e[1], e[0]};
    cmp_all();
  endtask

  // full-scale code into all channels
  task automatic t_wr_all();
    frame(2'h0, 2'h2, 12'hfff, 16);
    e = '{default: 12'hfff};
    eo = {4{12'hfff}};
    cmp_all();
  endtask

  // select rises after ten bits: nothing changes
  task automatic t_abort();
    frame(2'h3, 2'h2, 12'h000, 10);
    cmp_all();
  endtask

  // trailing clock pulses with data high are ignored
  task automatic t_extra();
    frame(2'h0, 2'h1, 12'h123, 20);
    e[0] = 12'h123;
    eo = {e[3], e[2], e[1], e[0]};
    cmp_all();
  endtask

  // every termination code, registers untouched
  task automatic t_power();
    qdc_term_t et;
    for (int a = 0; a < 4; a++) begin
      frame(2'(a), 2'h3, 12'h000, 16);
      et = (a == 1) ? QDC_TERM_GND_2K5 :
           (a == 2) ? QDC_TERM_GND_100K : QDC_TERM_NONE;
      chk("pd", 48'(pd), 48'h1);
      chk("term", 48'(term), 48'(et));
      cmp_all();
    end
  endtask

  // leave power-down with a write to the last channel
  task automatic t_wake();
    frame(2'h3, 2'h0, 12'h0a1, 16);
    e[3] = 12'h0a1;
    chk("pd", 48'(pd), 48'h0);
    cmp_all();
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    e = '{default: 12'h000};
    eo = 48'h0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_wr_only();
    t_wr_upd();
    t_wr_all();
    t_abort();
    t_extra();
    t_power();
    t_wake();
    tally_and_finish();
  end

  // cuts a hang short
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule
